//--- rtl/pbx_defs.svh
`ifndef PBX_DEFS_SVH
`define PBX_DEFS_SVH
// register addresses
`define PBX_ADDR_BYPASS 5'h12
`define PBX_ADDR_RXERR 5'h13
`define PBX_ADDR_FCAR 5'h14
`define PBX_ADDR_LDISC 5'h15
`define PBX_ADDR_EXT 5'h16
// bypass control field positions
`define PBX_BP_TXDIS 15
`define PBX_BP_4B5B 14
`define PBX_BP_SCR 13
`define PBX_BP_DESCR 12
`define PBX_BP_PCSRX 11
`define PBX_BP_PCSTX 10
`define PBX_BP_LFI 9
`define PBX_BP_XOVER 7
`define PBX_BP_RSVD6 6
`define PBX_BP_PAIR 5
`define PBX_BP_POL 4
`define PBX_BP_PDET 3
// extended control/status field positions
`define PBX_EX_LINK 15
`define PBX_EX_JAB 14
`define PBX_EX_ECHO 13
`define PBX_EX_SQE 12
`define PBX_EX_SQH 11
`define PBX_EX_SQL 10
`define PBX_EX_RETAIN 9
`define PBX_EX_EOF 8
`define PBX_EX_DISC 7
`define PBX_EX_LNK10 6
`define PBX_EX_BCAST 0
// reset values
`define PBX_BP_RESET 16'h0088
`define PBX_EX_RESET 16'h3200
// mask of read-write bits per register
`define PBX_BP_WMASK 16'hFEF8
`define PBX_EX_WMASK 16'hFE01
// sticky bits (retained on soft reset when enabled)
`define PBX_BP_STICKY 16'h00B8
`define PBX_EX_STICKY 16'hFC01
`define PBX_EX_SUPER 16'h0200
`define PBX_CNT_MAX 8'hFF
`define PBX_CNT_ZERO 8'h00
`define PBX_SQ_RSVD 2'b11
`endif

//--- rtl/pbx_pkg.sv
package pbx_pkg;
  // management access request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] addr;
    logic [15:0] wdata;
  } pbx_req_t;
  // per-phy datapath controls
  typedef struct packed {
    logic tx_disable;
    logic byp_4b5b;
    logic byp_scr;
    logic byp_descr;
    logic byp_pcs_rx;
    logic byp_pcs_tx;
    logic byp_lfi;
    logic xover_dis;
    logic pair_swap_dis;
    logic pol_corr_dis;
    logic pdet_honour;
    logic link_force;
    logic jabber_dis;
    logic echo_dis;
    logic sqe_dis;
    logic [1:0] squelch;
  } pbx_ctl_t;
  // line events
  typedef struct packed {
    logic rx_err;
    logic false_car;
    logic link_disc;
    logic eof_err;
    logic disc10;
    logic link10;
  } pbx_evt_t;
endpackage : pbx_pkg

//--- rtl/pbx_regs.sv
`timescale 1ns/10ps
`default_nettype none
`include "pbx_defs.svh"
// Summary of operation
// - bypass bit 15 turns transmitter off
// - bits 14..12 skip 4B5B, scrambler, descrambler
// - bits 11, 10 skip PCS receive, transmit
// - bit 9 skips link fail inhibit timer
// - sticky bit 7 disables forced-speed crossover
// - sticky bit 5 disables pair swap
// - sticky bit 4 disables polarity correction
// - sticky bit 3 honours advertised ability
// - three 8-bit counters saturate at 255
// - counters reset zero, clear on read
// - ext bit 15 forces link pass
// - ext bit 14 disables jabber detect
// - ext bit 13 disables echo
// - ext bit 12 disables signal quality error
// - ext 11:10 selects squelch threshold
// - retention bit keeps sticky bits on soft reset
// - super-sticky bits survive every soft reset
// - ext bit 8 latches EOF error, clears on read
// - bit 7 latched disconnect, bit 6 live link
// - broadcast bit applies writes to all phys
// - reads return only the addressed phy
module pbx_regs
  import pbx_pkg::*;
#(
  parameter int NUM_PHY = 4
)
(
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RSTN,
  // management access, addressed phy and soft reset pulse
  input wire pbx_pkg::pbx_req_t REQ,
  input wire logic [$clog2(NUM_PHY)-1:0] PHY_SEL,
  input wire logic SOFT_RESET,
  // line events per phy
  input wire pbx_pkg::pbx_evt_t EVT [NUM_PHY],
  // read data, valid the cycle after a read
  output logic [15:0] RDATA,
  output logic RVALID,
  // controls per phy
  output pbx_pkg::pbx_ctl_t CTL [NUM_PHY]
);
  import pbx_pkg::*;
  localparam int SW = (NUM_PHY > 1) ? $clog2(NUM_PHY) : 1;
  // counter width, tied to the saturation value in the defs header
  localparam int CNT_W = 8;
  // =====================================================
  // parameter checks
  // one phy would leave the select with no bits; 32 is kept as a
  // sanity bound on the select width
  if (NUM_PHY < 2 || NUM_PHY > 32)
  begin : g_bad_num_phy
    $error("pbx_regs: NUM_PHY out of range");
  end
  // =====================================================
  // register state, one copy per phy except the shared read data, valid and broadcast decode
  logic [15:0] bp_q [NUM_PHY];
  logic [15:0] bp_d [NUM_PHY];
  logic [15:0] ex_q [NUM_PHY];
  logic [15:0] ex_d [NUM_PHY];
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;
  logic rvalid_q;
  logic rvalid_d;
  pbx_ctl_t ctl_q [NUM_PHY];
  pbx_ctl_t ctl_d [NUM_PHY];
  logic [CNT_W-1:0] cnt_rx [NUM_PHY];
  logic [CNT_W-1:0] cnt_fc [NUM_PHY];
  logic [CNT_W-1:0] cnt_ld [NUM_PHY];
  logic bcast;
  // addressed phy's values, picked once for the read mux
  logic [15:0] view_bp;
  logic [15:0] view_ex;
  logic [CNT_W-1:0] view_rx;
  logic [CNT_W-1:0] view_fc;
  logic [CNT_W-1:0] view_ld;
  logic view_lnk;
  // =====================================================
  // broadcast decode
  // the enable is the value held before the write, so a write that
  // clears it is still broadcast; only the next write goes to one phy
  // broadcast follows the addressed phy's enable
  assign bcast = ex_q[PHY_SEL][`PBX_EX_BCAST];
  // one slice per phy: strobes, counters, registers and controls
  genvar g;
  generate
    for (g = 0; g < NUM_PHY; g++)
    begin : g_phy
      logic sel_w;
      logic sel_r;
      logic wr_bp;
      logic wr_ex;
      logic rd_ex;
      logic clr_rx;
      logic clr_fc;
      logic clr_ld;
      // a write reaches every phy under broadcast
      assign sel_w = REQ.wr && (bcast || PHY_SEL == SW'(g));
      // a read touches only the addressed phy
      assign sel_r = REQ.rd && PHY_SEL == SW'(g);
      // per-register strobes of this phy
      assign wr_bp = sel_w && REQ.addr == `PBX_ADDR_BYPASS;
      assign wr_ex = sel_w && REQ.addr == `PBX_ADDR_EXT;
      assign rd_ex = sel_r && REQ.addr == `PBX_ADDR_EXT;
      assign clr_rx = sel_r && REQ.addr == `PBX_ADDR_RXERR;
      assign clr_fc = sel_r && REQ.addr == `PBX_ADDR_FCAR;
      assign clr_ld = sel_r && REQ.addr == `PBX_ADDR_LDISC;
      // =====================================================
      // error counters
      // an event in the read cycle lands after the clear, so none is lost
      pbx_sat_cnt #(.WIDTH(CNT_W)) u_rx
      (
        .clk(CORE_CLK),
        .rst_n(RSTN),
        .inc(EVT[g].rx_err),
        .clr(clr_rx),
        .count(cnt_rx[g])
      );
      pbx_sat_cnt #(.WIDTH(CNT_W)) u_fc
      (
        .clk(CORE_CLK),
        .rst_n(RSTN),
        .inc(EVT[g].false_car),
        .clr(clr_fc),
        .count(cnt_fc[g])
      );
      pbx_sat_cnt #(.WIDTH(CNT_W)) u_ld
      (
        .clk(CORE_CLK),
        .rst_n(RSTN),
        .inc(EVT[g].link_disc),
        .clr(clr_ld),
        .count(cnt_ld[g])
      );
      // =====================================================
      // register next state
      // soft reset wins over a write in the same cycle
      always_comb
      begin
        logic [15:0] keep;
        keep = 16'h0000;
        bp_d[g] = bp_q[g];
        ex_d[g] = ex_q[g];
        // the retention enable used is the value held before this reset
        if (SOFT_RESET)
        begin
          // retention enable picks sticky keep mask
          keep = ex_q[g][`PBX_EX_RETAIN] ? `PBX_EX_STICKY : `PBX_EX_SUPER;
          keep = keep | `PBX_EX_SUPER;
          ex_d[g] = (ex_q[g] & keep & `PBX_EX_WMASK) | (`PBX_EX_RESET & ~keep);
          // bypass has no super-sticky bit, so without retention all resets
          keep = ex_q[g][`PBX_EX_RETAIN] ? `PBX_BP_STICKY : 16'h0000;
          bp_d[g] = (bp_q[g] & keep) | (`PBX_BP_RESET & ~keep);
        end
        else if (wr_bp)
          bp_d[g] = REQ.wdata & `PBX_BP_WMASK;
        else if (wr_ex)
        begin
          ex_d[g] = (REQ.wdata & `PBX_EX_WMASK) | (ex_q[g] & ~`PBX_EX_WMASK);
          // the rest of that write is still taken, only the field holds
          // reserved squelch code is not stored
          if (REQ.wdata[`PBX_EX_SQH:`PBX_EX_SQL] == `PBX_SQ_RSVD)
            ex_d[g][`PBX_EX_SQH:`PBX_EX_SQL] = ex_q[g][`PBX_EX_SQH:`PBX_EX_SQL];
        end
        // flags clear on a read of the register; an event in that same
        // cycle is applied after, so it sets the flag again
        // EOF flag cleared by read, set wins
        if (rd_ex)
        begin
          ex_d[g][`PBX_EX_EOF] = 1'b0;
          ex_d[g][`PBX_EX_DISC] = 1'b0;
        end
        if (EVT[g].eof_err)
          ex_d[g][`PBX_EX_EOF] = 1'b1;
        if (EVT[g].disc10)
          ex_d[g][`PBX_EX_DISC] = 1'b1;
        // the live link bit is never stored, the read mux fills it in
        ex_d[g][`PBX_EX_LNK10] = 1'b0;
      end
      // register state, reset to the power-on values
      always_ff @(posedge CORE_CLK)
      begin
        if (!RSTN)
        begin
          bp_q[g] <= `PBX_BP_RESET;
          ex_q[g] <= `PBX_EX_RESET;
        end
        else
        begin
          bp_q[g] <= bp_d[g];
          ex_q[g] <= ex_d[g];
        end
      end
      // =====================================================
      // control outputs, registered from the next state
      // taken from the next state so a control moves on the same edge as
      // its register bit; during reset every control is held low
      always_comb
      begin
        ctl_d[g].tx_disable = bp_d[g][`PBX_BP_TXDIS];
        ctl_d[g].byp_4b5b = bp_d[g][`PBX_BP_4B5B];
        ctl_d[g].byp_scr = bp_d[g][`PBX_BP_SCR];
        ctl_d[g].byp_descr = bp_d[g][`PBX_BP_DESCR];
        ctl_d[g].byp_pcs_rx = bp_d[g][`PBX_BP_PCSRX];
        ctl_d[g].byp_pcs_tx = bp_d[g][`PBX_BP_PCSTX];
        ctl_d[g].byp_lfi = bp_d[g][`PBX_BP_LFI];
        ctl_d[g].xover_dis = bp_d[g][`PBX_BP_XOVER];
        ctl_d[g].pair_swap_dis = bp_d[g][`PBX_BP_PAIR];
        ctl_d[g].pol_corr_dis = bp_d[g][`PBX_BP_POL];
        ctl_d[g].pdet_honour = bp_d[g][`PBX_BP_PDET];
        ctl_d[g].link_force = ex_d[g][`PBX_EX_LINK];
        ctl_d[g].jabber_dis = ex_d[g][`PBX_EX_JAB];
        ctl_d[g].echo_dis = ex_d[g][`PBX_EX_ECHO];
        ctl_d[g].sqe_dis = ex_d[g][`PBX_EX_SQE];
        ctl_d[g].squelch = ex_d[g][`PBX_EX_SQH:`PBX_EX_SQL];
      end
      // control registers
      always_ff @(posedge CORE_CLK)
      begin
        if (!RSTN)
          ctl_q[g] <= pbx_ctl_t'(17'h0_0000);
        else
          ctl_q[g] <= ctl_d[g];
      end
      assign CTL[g] = ctl_q[g];
    end
  endgenerate
  // =====================================================
  // read path
  // addressed phy views; keep PHY_SEL below NUM_PHY, since a select past
  // the last phy on a count that is not a power of two reads unknown
  assign view_bp = bp_q[PHY_SEL];
  assign view_ex = ex_q[PHY_SEL];
  assign view_rx = cnt_rx[PHY_SEL];
  assign view_fc = cnt_fc[PHY_SEL];
  assign view_ld = cnt_ld[PHY_SEL];
  assign view_lnk = EVT[PHY_SEL].link10;
  // data is registered, so the live link bit is sampled here
  // with no read the data is held at zero, so nothing stale shows
  always_comb
  begin
    rdata_d = 16'h0000;
    rvalid_d = REQ.rd;
    if (REQ.rd)
    begin
      // unmapped and reserved bits read zero, except bypass bit 6, which is writable and reads back
      case (REQ.addr)
        `PBX_ADDR_BYPASS: rdata_d = view_bp;
        `PBX_ADDR_RXERR: rdata_d = {8'h00, view_rx};
        `PBX_ADDR_FCAR: rdata_d = {8'h00, view_fc};
        `PBX_ADDR_LDISC: rdata_d = {8'h00, view_ld};
        `PBX_ADDR_EXT:
        begin
          rdata_d = view_ex;
          rdata_d[`PBX_EX_LNK10] = view_lnk;
        end
        default: rdata_d = 16'h0000;
      endcase
    end
  end
  // =====================================================
  // read data and valid registers
  always_ff @(posedge CORE_CLK)
  begin
    if (!RSTN)
    begin
      rdata_q <= 16'h0000;
      rvalid_q <= 1'b0;
    end
    else
    begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end
  assign RDATA = rdata_q;
  assign RVALID = rvalid_q;
endmodule : pbx_regs
`default_nettype wire

//--- rtl/pbx_sat_cnt.sv
`timescale 1ns/10ps
`default_nettype none
`include "pbx_defs.svh"
module pbx_sat_cnt
#(
  parameter int WIDTH = 8
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic inc,
  input wire logic clr,
  output logic [WIDTH-1:0] count
);
  logic [WIDTH-1:0] cnt_q;
  logic [WIDTH-1:0] cnt_d;
  if (WIDTH != 8)
  begin : g_bad_width
    $error("pbx_sat_cnt: width must be 8");
  end
  // =====================================================
  // counting
  // read clears, an event in the read cycle counts as one
  always_comb
  begin
    cnt_d = cnt_q;
    if (clr)
      cnt_d = inc ? 8'h01 : `PBX_CNT_ZERO;
    else if (inc && cnt_q != `PBX_CNT_MAX)
      cnt_d = cnt_q + 8'h01;
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      cnt_q <= `PBX_CNT_ZERO;
    else
      cnt_q <= cnt_d;
  end
  assign count = cnt_q;
endmodule : pbx_sat_cnt
`default_nettype wire

//--- sim/pbx_mgmt_host.sv
`timescale 1ns/10ps
`default_nettype none
// ====================
// management controller model, one access at a time
module pbx_mgmt_host
  import pbx_pkg::*;
#(
  parameter int NUM_PHY = 4
)
(
  // clock
  input wire logic clk,
  // request side
  output pbx_pkg::pbx_req_t req,
  output logic [$clog2(NUM_PHY)-1:0] sel,
  // answer side
  input wire logic [15:0] rdata,
  input wire logic rvalid
);
  import pbx_pkg::*;
  // idle bus until the first access
  initial
  begin
    req = '0;
    sel = '0;
  end
  // one-cycle request, launched at the falling edge
  task automatic access(input logic w, input logic [1:0] p, input logic [4:0] a,
    input logic [15:0] d, output logic [15:0] q);
    @(negedge clk);
    req = {w, !w, a, d};
    sel = p;
    @(negedge clk);
    req = '0;
    // answer stands one cycle only, so take it here
    q = rvalid ? rdata : 16'hxxxx;
  endtask : access
endmodule : pbx_mgmt_host
`default_nettype wire

//--- sim/pbx_regs_sva.sv
`timescale 1ns/10ps
`default_nettype none
// ====================
// port checker
module pbx_regs_sva
  import pbx_pkg::*;
#(
  parameter int NUM_PHY = 4
)
(
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RSTN,
  // access side
  input wire pbx_pkg::pbx_req_t REQ,
  input wire logic [$clog2(NUM_PHY)-1:0] PHY_SEL,
  input wire logic SOFT_RESET,
  // answers
  input wire logic [15:0] RDATA,
  input wire logic RVALID,
  input wire pbx_pkg::pbx_ctl_t CTL [NUM_PHY]
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);
  // writes to phy 0 that no soft reset overrides
  logic wr0;
  assign wr0 = REQ.wr && PHY_SEL == '0 && !SOFT_RESET;
  a_rd_answer: assert property (REQ.rd |=> RVALID)
    else $error("read not answered");
  a_no_stray: assert property (!REQ.rd |=> !RVALID && RDATA == 16'h0000)
    else $error("stray read data");
  a_cnt_upper: assert property (REQ.rd && REQ.addr inside {5'h13, 5'h14, 5'h15} |=>
    RDATA[15:8] == 8'h00) else $error("counter upper byte set");
  a_bp_rsvd: assert property (REQ.rd && REQ.addr == 5'h12 |=>
    RDATA[8] == 1'b0 && RDATA[2:0] == 3'h0) else $error("bypass reserved bits set");
  a_ex_rsvd: assert property (REQ.rd && REQ.addr == 5'h16 |=> RDATA[5:1] == 5'h00)
    else $error("extended reserved bits set");
  a_unmapped: assert property (REQ.rd && !(REQ.addr inside {[5'h12:5'h16]}) |=>
    RDATA == 16'h0000) else $error("unmapped read not zero");
  a_txdis_track: assert property (wr0 && REQ.addr == 5'h12 |=>
    CTL[0].tx_disable == $past(REQ.wdata[15])) else $error("transmit disable wrong");
  a_lfi_track: assert property (wr0 && REQ.addr == 5'h12 |=>
    CTL[0].byp_lfi == $past(REQ.wdata[9])) else $error("timer bypass wrong");
  a_sq_keep: assert property (wr0 && REQ.addr == 5'h16 && REQ.wdata[11:10] == 2'b11 |=>
    $stable(CTL[0].squelch)) else $error("reserved squelch taken");
endmodule : pbx_regs_sva
bind pbx_regs pbx_regs_sva #(.NUM_PHY(NUM_PHY)) u_sva (.CORE_CLK(CORE_CLK), .RSTN(RSTN),
  .REQ(REQ), .PHY_SEL(PHY_SEL), .SOFT_RESET(SOFT_RESET), .RDATA(RDATA), .RVALID(RVALID),
  .CTL(CTL));
`default_nettype wire

//--- sim/phy_bypass_errcount_ext_ctrl_bench.sv
`timescale 1ns/10ps
`default_nettype none
// ====================
// bench
module phy_bypass_errcount_ext_ctrl_bench;
  import pbx_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic srst = 1'b0;
  pbx_req_t req;
  logic [1:0] sel;
  pbx_evt_t evt [4] = '{default: '0};
  logic [15:0] rdata;
  logic rvalid;
  pbx_ctl_t ctl [4];
  logic [15:0] q;
  int n_fail = 0;
  int comparisons = 0;
  // write, readback value
  logic [15:0] rows [8][3] = '{'{16'h0012, 16'hffff, 16'hfef8}, '{16'h0012, 16'h0000, 16'h0000},
    '{16'h0016, 16'hffff, 16'hf201}, '{16'h0016, 16'h0400, 16'h0400},
    '{16'h0016, 16'h0800, 16'h0800}, '{16'h0016, 16'h0c00, 16'h0800},
    '{16'h0017, 16'hffff, 16'h0000}, '{16'h0010, 16'h1234, 16'h0000}};
  // 4 ns clock
  always #2 clk = !clk;
  pbx_regs #(.NUM_PHY(4)) dut (.CORE_CLK(clk), .RSTN(rstn), .REQ(req), .PHY_SEL(sel),
    .SOFT_RESET(srst), .EVT(evt), .RDATA(rdata), .RVALID(rvalid), .CTL(ctl));
  pbx_mgmt_host #(.NUM_PHY(4)) host (.clk(clk), .req(req), .sel(sel), .rdata(rdata),
    .rvalid(rvalid));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [1:0] p, input logic [4:0] a, input logic [15:0] d);
    host.access(1'b1, p, a, d, q);
  endtask : wr
  task automatic rd(input logic [1:0] p, input logic [4:0] a);
    host.access(1'b0, p, a, 16'h0000, q);
  endtask : rd
  // one-cycle event pulses on one phy, field k
  task automatic pulse(input int p, input int k, input int n);
    repeat (n)
    begin
      @(negedge clk) evt[p][k] = 1'b1;
      @(negedge clk) evt[p][k] = 1'b0;
    end
  endtask : pulse
  task automatic reset_all();
    @(negedge clk) rstn = 1'b0;
    repeat (5) @(negedge clk);
    rstn = 1'b1;
  endtask : reset_all
  task automatic soft_reset();
    @(negedge clk) srst = 1'b1;
    @(negedge clk) srst = 1'b0;
  endtask : soft_reset
  task automatic complete_run();
    if (n_fail == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : complete_run
  // hang guard, far beyond the few thousand ns needed
  initial
  begin
    #100000;
    n_fail++;
    complete_run();
  end
  // main sequence
  initial
  begin
    repeat (5) @(negedge clk);
    rstn = 1'b1;
    foreach (rows[i])
    begin
      wr(2'd0, rows[i][0][4:0], rows[i][1]);
      rd(2'd0, rows[i][0][4:0]);
      check(q, rows[i][2]);
    end
    check(ctl[0], 17'h0_0002);
    reset_all();
    rd(2'd0, 5'h12);
    check(q, 16'h0088);
    rd(2'd0, 5'h16);
    check(q, 16'h3200);
    check(ctl[0], 17'h0_024c);
    wr(2'd1, 5'h12, 16'hfef8);
    check(ctl[1], 17'h1_ffcc);
    check(ctl[0], 17'h0_024c);
    // saturation on the receive error counter, clear on read on all three counters
    pulse(2, 5, 260);
    rd(2'd2, 5'h13);
    check(q, 16'h00ff);
    for (int k = 0; k < 3; k++)
    begin
      pulse(2, 5 - k, 3);
      rd(2'd2, 5'h13 + k[4:0]);
      check(q, 16'h0003);
      rd(2'd2, 5'h13 + k[4:0]);
      check(q, 16'h0000);
    end
    // latched status clears on read, live link does not
    pulse(3, 2, 1);
    pulse(3, 1, 1);
    evt[3][0] = 1'b1;
    rd(2'd3, 5'h16);
    check(q, 16'h33c0);
    rd(2'd3, 5'h16);
    check(q, 16'h3240);
    soft_reset();
    rd(2'd1, 5'h12);
    check(q, 16'h00b8);
    wr(2'd1, 5'h16, 16'h0000);
    soft_reset();
    rd(2'd1, 5'h16);
    check(q, 16'h3000);
    rd(2'd1, 5'h12);
    check(q, 16'h0088);
    // broadcast on, then off again
    wr(2'd0, 5'h16, 16'hf201);
    wr(2'd0, 5'h12, 16'h8000);
    check(ctl[0], 17'h1_003c);
    check(ctl[3], 17'h1_000c);
    rd(2'd3, 5'h12);
    check(q, 16'h8000);
    pulse(0, 5, 2);
    rd(2'd1, 5'h13);
    check(q, 16'h0000);
    wr(2'd0, 5'h16, 16'h3200);
    wr(2'd0, 5'h12, 16'h0000);
    rd(2'd3, 5'h12);
    check(q, 16'h8000);
    check(ctl[3].tx_disable, 1'b1);
    complete_run();
  end
endmodule : phy_bypass_errcount_ext_ctrl_bench
`default_nettype wire
